// ---- logic/strap_pkg.sv ----
// Package: constants and carrier types for strap sampling and chip-select decode
package strap_pkg;
    localparam logic [9:0] ADDR_DISK_PRI_BASE  = 10'h1F0;
    localparam logic [9:0] ADDR_DISK_SEC_BASE  = 10'h170;
    localparam logic [9:0] ADDR_DISK_XT_BASE   = 10'h320;
    localparam logic [9:0] ADDR_AUX_PRI_BASE   = 10'h3F6;
    localparam logic [9:0] ADDR_AUX_SEC_BASE   = 10'h376;
    localparam logic [9:0] ADDR_JOYSTICK       = 10'h201;
    localparam logic [9:0] MASK_DISK_AT        = 10'h3F8;
    localparam logic [9:0] MASK_DISK_XT        = 10'h3FC;
    localparam logic [9:0] MASK_AUX            = 10'h3FE;
    localparam logic [9:0] MASK_EXACT          = 10'h3FF;
    localparam logic [7:0] CFG0_RESET          = 8'h00;
    localparam logic [7:0] CFG1_RESET          = 8'h00;
    localparam int         CFG0_DISK_EN_BIT    = 7;
    localparam int         CFG0_FLOPPY_EN_BIT  = 6;
    localparam int         CFG0_JOY_EN_BIT     = 4;
    localparam int         CFG0_DISK_PSEL_BIT  = 3;
    localparam int         CFG0_PRN_MODE_BIT   = 2;
    localparam int         CFG0_PRN_SEL1_BIT   = 1;
    localparam int         CFG0_PRN_SEL0_BIT   = 0;
    localparam int         CFG1_SER_SEL2_BIT   = 2;
    localparam int         CFG1_SER_SEL1_BIT   = 1;
    localparam int         CFG1_SER_SEL0_BIT   = 0;

    typedef enum logic [1:0] {
        HW_CONFIG,
        SW_CONFIG
    } cfg_mode_e;

    // Host bus request bundle
    typedef struct packed {
        logic [9:0] addr;
        logic       rd_n;
        logic       wr_n;
        logic       aen;
    } host_req_s;

    // Normal-operation drive values of the shared pins
    typedef struct packed {
        logic rts1_n;
        logic dtr1_n;
        logic txd1;
        logic rts2_n;
        logic dtr2_n;
        logic txd2;
        logic test_disk;
        logic test_floppy;
    } pin_func_s;

    // Captured strap configuration
    typedef struct packed {
        logic [7:0] cfg0;
        logic [2:0] cfg1;
        logic       floppy_alt;
    } strap_cfg_s;
endpackage

// ---- logic/addr_decode.sv ----
// Address decode of disk chip selects and joystick strobes
module addr_decode
    import strap_pkg::*;
(
    input  wire host_req_s  req_i,
    input  wire strap_cfg_s cfg_i,
    input  wire logic       xt_mode_i,
    output logic            cs_main_o,
    output logic            cs_aux_o,
    output logic            joy_rd_o,
    output logic            joy_wr_o,
    output logic            dir_to_host_o
);
    function automatic logic hit(input logic [9:0] a, input logic [9:0] base,
                                 input logic [9:0] mask);
        hit = ((a & mask) == (base & mask));
    endfunction

    logic disk_en;
    logic joy_en;
    logic pri;
    logic act;
    logic joy_hit;

    always_comb begin
        disk_en = cfg_i.cfg0[CFG0_DISK_EN_BIT];
        joy_en  = cfg_i.cfg0[CFG0_JOY_EN_BIT];
        pri     = cfg_i.cfg0[CFG0_DISK_PSEL_BIT];
        act     = !req_i.aen && (!req_i.rd_n || !req_i.wr_n);
        if (xt_mode_i) begin
            cs_main_o = act && disk_en && hit(req_i.addr, ADDR_DISK_XT_BASE, MASK_DISK_XT);
        end else begin
            cs_main_o = act && disk_en &&
                hit(req_i.addr, pri ? ADDR_DISK_PRI_BASE : ADDR_DISK_SEC_BASE,
                    MASK_DISK_AT);
        end
        cs_aux_o = act && disk_en && !xt_mode_i &&
            hit(req_i.addr, pri ? ADDR_AUX_PRI_BASE : ADDR_AUX_SEC_BASE, MASK_AUX);
        joy_hit  = !req_i.aen && joy_en && hit(req_i.addr, ADDR_JOYSTICK, MASK_EXACT);
        joy_rd_o = joy_hit && !req_i.rd_n;
        joy_wr_o = joy_hit && !req_i.wr_n;
        dir_to_host_o = !req_i.rd_n && (cs_main_o || cs_aux_o || joy_rd_o);
    end
endmodule

// ---- logic/strap_sampling_and_cs_decode.sv ----
// Top: strap sampling on shared pins, chip-select decode, bus direction, isolation
//==============================================================================
module strap_sampling_and_cs_decode
    import strap_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic       host_reset_i,
    input  wire logic       power_good_i,
    input  wire logic       xt_mode_i,
    input  wire host_req_s  host_req_i,
    input  wire pin_func_s  pin_func_i,
    input  wire logic       disk_cs_main_n_i,
    input  wire logic       joystick_read_strobe_n_i,
    input  wire logic       joystick_write_strobe_n_i,
    input  wire logic [2:0] serial1_pins_i,
    input  wire logic [2:0] serial2_pins_i,
    input  wire logic       strap_disk_enable_i,
    input  wire logic       strap_floppy_alt_ports_i,
    output logic            disk_cs_main_n_o,
    output logic            disk_cs_main_n_oe_o,
    output logic            disk_cs_aux_n_o,
    output logic            disk_cs_aux_n_oe_o,
    output logic            joystick_read_strobe_n_o,
    output logic            joystick_read_strobe_n_oe_o,
    output logic            joystick_write_strobe_n_o,
    output logic            joystick_write_strobe_n_oe_o,
    output logic [2:0]      serial1_pins_o,
    output logic [2:0]      serial1_pins_oe_o,
    output logic [2:0]      serial2_pins_o,
    output logic [2:0]      serial2_pins_oe_o,
    output logic            strap_disk_enable_o,
    output logic            strap_disk_enable_oe_o,
    output logic            strap_floppy_alt_ports_o,
    output logic            strap_floppy_alt_ports_oe_o,
    output logic            bus_buffer_direction_o,
    output logic            bus_buffer_direction_oe_o,
    output strap_cfg_s      cfg_o
);
    //==========================================================================
    // Strap capture
    strap_cfg_s cfg_r;
    strap_cfg_s cfg_nxt;
    strap_cfg_s smp_r;
    strap_cfg_s smp_nxt;
    cfg_mode_e  mode_r;
    cfg_mode_e  mode_nxt;
    host_req_s  req_gated;
    logic       run;

    always_comb begin
        smp_nxt  = smp_r;
        cfg_nxt  = cfg_r;
        mode_nxt = mode_r;
        run      = power_good_i && !host_reset_i;
        if (power_good_i && host_reset_i) begin
            // Pins are inputs here; keep the latest level
            smp_nxt.cfg0[CFG0_FLOPPY_EN_BIT] = disk_cs_main_n_i;
            smp_nxt.cfg0[CFG0_DISK_PSEL_BIT] = joystick_read_strobe_n_i;
            smp_nxt.cfg0[CFG0_JOY_EN_BIT]    = joystick_write_strobe_n_i;
            smp_nxt.cfg1 = {serial1_pins_i[2], serial1_pins_i[1], serial1_pins_i[0]};
            smp_nxt.cfg0[CFG0_PRN_SEL0_BIT]  = serial2_pins_i[0];
            smp_nxt.cfg0[CFG0_PRN_SEL1_BIT]  = serial2_pins_i[1];
            smp_nxt.cfg0[CFG0_PRN_MODE_BIT]  = serial2_pins_i[2];
            smp_nxt.cfg0[CFG0_DISK_EN_BIT]   = strap_disk_enable_i;
            smp_nxt.floppy_alt               = strap_floppy_alt_ports_i;
        end
        case (mode_r)
            HW_CONFIG: begin
                if (run) begin
                    cfg_nxt  = smp_r;
                    mode_nxt = SW_CONFIG;
                end
            end
            SW_CONFIG: begin
                if (power_good_i && host_reset_i) begin
                    mode_nxt = HW_CONFIG;
                end
            end
            default: mode_nxt = HW_CONFIG;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            smp_r  <= '0;
            cfg_r  <= '{cfg0: CFG0_RESET, cfg1: CFG1_RESET[2:0], floppy_alt: 1'b0};
            mode_r <= HW_CONFIG;
        end else begin
            smp_r  <= smp_nxt;
            cfg_r  <= cfg_nxt;
            mode_r <= mode_nxt;
        end
    end

    //==========================================================================
    // Decode
    logic cs_main;
    logic cs_aux;
    logic joy_rd;
    logic joy_wr;
    logic dir_host;

    always_comb begin
        req_gated = host_req_i;
        if (!run) begin
            // Inputs ignored while isolated or in reset
            req_gated.rd_n = 1'b1;
            req_gated.wr_n = 1'b1;
        end
    end

    addr_decode u_dec (
        .req_i         (req_gated),
        .cfg_i         (cfg_r),
        .xt_mode_i     (xt_mode_i),
        .cs_main_o     (cs_main),
        .cs_aux_o      (cs_aux),
        .joy_rd_o      (joy_rd),
        .joy_wr_o      (joy_wr),
        .dir_to_host_o (dir_host)
    );

    //==========================================================================
    // Pin drive
    logic [25:0] pins_r;
    logic [25:0] pins_nxt;

    always_comb begin
        pins_nxt = '0;
        if (run) begin
            // Value, enable pairs; shared pins back to normal use
            pins_nxt = {!cs_main, 1'b1, !cs_aux, 1'b1, !joy_rd, 1'b1,
                        !joy_wr, 1'b1,
                        pin_func_i.txd1, pin_func_i.dtr1_n, pin_func_i.rts1_n, 3'b111,
                        pin_func_i.txd2, pin_func_i.dtr2_n, pin_func_i.rts2_n, 3'b111,
                        pin_func_i.test_disk, 1'b1, pin_func_i.test_floppy, 1'b1,
                        dir_host, 1'b1};
        end else if (power_good_i) begin
            // Aux select stays output in reset
            pins_nxt[23:22] = 2'b11;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pins_r <= '0;
        end else begin
            pins_r <= pins_nxt;
        end
    end

    assign {disk_cs_main_n_o, disk_cs_main_n_oe_o, disk_cs_aux_n_o, disk_cs_aux_n_oe_o,
            joystick_read_strobe_n_o, joystick_read_strobe_n_oe_o,
            joystick_write_strobe_n_o, joystick_write_strobe_n_oe_o,
            serial1_pins_o, serial1_pins_oe_o, serial2_pins_o, serial2_pins_oe_o,
            strap_disk_enable_o, strap_disk_enable_oe_o,
            strap_floppy_alt_ports_o, strap_floppy_alt_ports_oe_o,
            bus_buffer_direction_o, bus_buffer_direction_oe_o} = pins_r;
    assign cfg_o = cfg_r;

    //==========================================================================
    // Checks
    sequence s_release;
        power_good_i && host_reset_i ##1 power_good_i && !host_reset_i;
    endsequence

    property p_capture;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        s_release |=> cfg_r == $past(smp_r);
    endproperty
    a_capture: assert property (p_capture) else $error("straps not captured");

    property p_isolate;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        !power_good_i |=> pins_r == '0;
    endproperty
    a_isolate: assert property (p_isolate) else $error("pins driven without power");

    property p_reset_inputs;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        host_reset_i |=> !disk_cs_main_n_oe_o && !joystick_read_strobe_n_oe_o
            && serial1_pins_oe_o == 3'b000 && serial2_pins_oe_o == 3'b000;
    endproperty
    a_reset_inputs: assert property (p_reset_inputs) else $error("strap pin driven");

    property p_normal_drive;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        run |=> disk_cs_main_n_oe_o && joystick_write_strobe_n_oe_o && serial2_pins_oe_o == 3'b111;
    endproperty
    a_normal_drive: assert property (p_normal_drive) else $error("pin not restored");

    property p_dma;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        run && host_req_i.aen |=> disk_cs_main_n_o && disk_cs_aux_n_o
            && joystick_read_strobe_n_o && joystick_write_strobe_n_o;
    endproperty
    a_dma: assert property (p_dma) else $error("decode during dma");

    property p_main_cs;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        run && !host_req_i.aen && !host_req_i.rd_n && !xt_mode_i
            && cfg_r.cfg0[CFG0_DISK_EN_BIT] && cfg_r.cfg0[CFG0_DISK_PSEL_BIT]
            && host_req_i.addr[9:3] == 7'h3E |=> !disk_cs_main_n_o;
    endproperty
    a_main_cs: assert property (p_main_cs) else $error("main select missed");

    property p_dir;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        host_req_i.rd_n |=> !bus_buffer_direction_o;
    endproperty
    a_dir: assert property (p_dir) else $error("direction without read");

    property p_joy_off;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        run && !cfg_r.cfg0[CFG0_JOY_EN_BIT]
            |=> joystick_read_strobe_n_o && joystick_write_strobe_n_o;
    endproperty
    a_joy_off: assert property (p_joy_off) else $error("joystick strobe while off");
endmodule

// ---- test/host_bus_model.sv ----
// Host I/O bus master model for the strap and chip-select block
module host_bus_model
    import strap_pkg::*;
(
    input  wire logic clk_sys_i,
    output host_req_s req_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req_o = '{addr: 10'h000, rd_n: 1'b1, wr_n: 1'b1, aen: 1'b0};

    // One access: strobes low while active, high when idle
    task automatic put(input logic [9:0] a, input logic rd, input logic wr, input logic e);
        @(posedge clk_sys_i);
        req_o <= '{addr: a, rd_n: ~rd, wr_n: ~wr, aen: e};
    endtask
endmodule

// ---- test/testbench.sv ----
// Self-checking bench: strap capture, decode, direction and isolation
module testbench
    import strap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [9:0] ADDRS [22] = '{10'h1EF, 10'h1F0, 10'h1F7, 10'h1F8, 10'h16F,
        10'h170, 10'h177, 10'h178, 10'h3F5, 10'h3F6, 10'h3F7, 10'h375, 10'h376, 10'h377,
        10'h378, 10'h200, 10'h201, 10'h202, 10'h31F, 10'h320, 10'h323, 10'h324};

    logic       clk_sys_i    = 1'b0;
    logic       resetn_i     = 1'b0;
    logic       host_reset_i = 1'b1;
    logic       power_good_i = 1'b1;
    logic       xt_mode_i    = 1'b0;
    logic [10:0] st          = 11'h000;
    logic [7:0] ecfg         = 8'h00;
    pin_func_s  pf           = 8'hA5;
    host_req_s  req;
    int         n_errors     = 0;
    int         checked      = 0;
    logic       cs_m, cs_m_oe, cs_a, cs_a_oe, jr, jr_oe, jw, jw_oe;
    logic       de, de_oe, fa, fa_oe, dir, dir_oe;
    logic [2:0] s1, s1_oe, s2, s2_oe;
    strap_cfg_s cfg;
    wire        main_w = cs_m_oe ? cs_m : st[5];
    wire        jr_w   = jr_oe ? jr : st[3];
    wire        jw_w   = jw_oe ? jw : st[4];
    wire        de_w   = de_oe ? de : st[6];
    wire        fa_w   = fa_oe ? fa : st[10];
    wire [2:0]  s1_w   = (s1_oe & s1) | (~s1_oe & st[9:7]);
    wire [2:0]  s2_w   = (s2_oe & s2) | (~s2_oe & st[2:0]);

    always #5 clk_sys_i = ~clk_sys_i;

    host_bus_model host (.clk_sys_i(clk_sys_i), .req_o(req));

    strap_sampling_and_cs_decode uut (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .host_reset_i(host_reset_i),
        .power_good_i(power_good_i), .xt_mode_i(xt_mode_i), .host_req_i(req),
        .pin_func_i(pf), .disk_cs_main_n_i(main_w), .joystick_read_strobe_n_i(jr_w),
        .joystick_write_strobe_n_i(jw_w), .serial1_pins_i(s1_w), .serial2_pins_i(s2_w),
        .strap_disk_enable_i(de_w), .strap_floppy_alt_ports_i(fa_w),
        .disk_cs_main_n_o(cs_m), .disk_cs_main_n_oe_o(cs_m_oe), .disk_cs_aux_n_o(cs_a),
        .disk_cs_aux_n_oe_o(cs_a_oe), .joystick_read_strobe_n_o(jr),
        .joystick_read_strobe_n_oe_o(jr_oe), .joystick_write_strobe_n_o(jw),
        .joystick_write_strobe_n_oe_o(jw_oe), .serial1_pins_o(s1), .serial1_pins_oe_o(s1_oe),
        .serial2_pins_o(s2), .serial2_pins_oe_o(s2_oe), .strap_disk_enable_o(de),
        .strap_disk_enable_oe_o(de_oe), .strap_floppy_alt_ports_o(fa),
        .strap_floppy_alt_ports_oe_o(fa_oe), .bus_buffer_direction_o(dir),
        .bus_buffer_direction_oe_o(dir_oe), .cfg_o(cfg));

    //==========================================================================
    // Helpers
    task automatic conclude;
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    // Expected {main, aux, joy read, joy write, direction}
    function automatic logic [4:0] exp_dec(input logic [9:0] a, input logic rd,
                                           input logic wr, input logic e);
        logic acc, m, x, j;
        acc = (rd | wr) & ~e;
        m = acc & ecfg[7] & (xt_mode_i ? a[9:2] == 8'hC8 : a[9:3] == (ecfg[3] ? 7'h3E : 7'h2E));
        x = acc & ecfg[7] & ~xt_mode_i & (a[9:1] == (ecfg[3] ? 9'h1FB : 9'h1BB));
        j = acc & ecfg[4] & (a == 10'h201);
        return {~m, ~x, ~(j & rd), ~(j & wr), (m | x | j) & rd};
    endfunction

    task automatic access(input logic [9:0] a, input logic rd, input logic wr, input logic e);
        logic [4:0] want;
        host.put(a, rd, wr, e);
        step(1);
        want = exp_dec(a, rd, wr, e);
        chk(16'({cs_m, cs_a, jr, jw}), 16'(want[4:1]));
        chk(16'(dir), 16'(want[0]));
    endtask

    //==========================================================================
    // Scenarios
    task automatic t_straps(input logic [10:0] v);
        @(posedge clk_sys_i);
        host_reset_i <= 1'b1;
        st <= v;
        step(3);
        chk(16'({cs_m_oe, jr_oe, jw_oe}), 16'h0000);
        chk(16'({s1_oe, s2_oe}), 16'h0000);
        chk(16'({de_oe, fa_oe}), 16'h0000);
        chk(16'({cs_a, cs_a_oe}), 16'h0003);
        @(posedge clk_sys_i);
        host_reset_i <= 1'b0;
        step(1);
        ecfg = {v[6], v[5], 1'b0, v[4], v[3], v[2:0]};
        chk(16'(cfg.cfg0), 16'(ecfg));
        chk(16'({cfg.cfg1, cfg.floppy_alt}), 16'({v[9:7], v[10]}));
        chk(16'({cs_m_oe, cs_a_oe, jr_oe, jw_oe, s1_oe, s2_oe}), 16'h03FF);
        chk(16'({de_oe, fa_oe, dir_oe}), 16'h0007);
        chk(16'({s1, s2, de, fa}), 16'({pf.txd1, pf.dtr1_n, pf.rts1_n, pf.txd2, pf.dtr2_n,
            pf.rts2_n, pf.test_disk, pf.test_floppy}));
        chk(16'({cs_m, cs_a, jr, jw}), 16'h000F);
    endtask

    task automatic t_decode;
        for (int x = 0; x < 2; x++) begin
            @(posedge clk_sys_i);
            xt_mode_i <= x[0];
            foreach (ADDRS[i]) begin
                access(ADDRS[i], 1'b1, 1'b0, 1'b0);
                access(ADDRS[i], 1'b0, 1'b1, 1'b0);
                access(ADDRS[i], 1'b1, 1'b0, 1'b1);
            end
        end
        @(posedge clk_sys_i);
        xt_mode_i <= 1'b0;
    endtask

    task automatic t_power;
        @(posedge clk_sys_i);
        power_good_i <= 1'b0;
        host_reset_i <= 1'b1;
        st           <= ~st;
        host.put(10'h170, 1'b1, 1'b0, 1'b0);
        step(1);
        chk(16'({cs_m_oe, cs_a_oe, jr_oe, jw_oe, s1_oe, s2_oe}), 16'h0000);
        chk(16'({de_oe, fa_oe, dir_oe}), 16'h0000);
        chk(16'({cs_m, cs_a, jr, jw, s1, s2, de, fa, dir}), 16'h0000);
        @(posedge clk_sys_i);
        power_good_i <= 1'b1;
        host_reset_i <= 1'b0;
        access(10'h170, 1'b1, 1'b0, 1'b0);
        chk(16'(cfg.cfg0), 16'(ecfg));
    endtask

    //==========================================================================
    // Main sequence and watchdog
    initial begin
        step(8);
        chk(16'({cs_m_oe, cs_a_oe, jr_oe, jw_oe, s1_oe, s2_oe}), 16'h0000);
        chk(16'({de_oe, fa_oe, dir_oe, dir}), 16'h0000);
        chk(16'(cfg), 16'h0000);
        repeat (8) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        t_straps(11'h6FA);
        t_decode();
        t_straps(11'h105);
        t_decode();
        t_straps(11'h050);
        t_decode();
        t_power();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        conclude();
    end
endmodule
